// [drc_refresh_ctrl.sv]
`timescale 1ns/1ps
module drc_refresh_ctrl
  import drc_pkg::*;
(
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset, low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic ext_access_busy, // External access in progress
  input wire logic sdram_access_busy, // SDRAM access in progress
  output logic refresh_strobe, // One refresh per pulse
  output logic self_refresh, // Self-refresh level
  output logic match_irq, // Match interrupt request
  output drc_geometry_t geometry // Column bits and bus width
);
  //==========================================================
  // Helpers
  function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h1: div_mask = 12'h003;
      3'h2: div_mask = 12'h00F;
      3'h3: div_mask = 12'h03F;
      3'h4: div_mask = 12'h0FF;
      3'h5: div_mask = 12'h3FF;
      3'h6: div_mask = 12'h7FF;
      default: div_mask = 12'hFFF;
    endcase
  endfunction : div_mask

  function automatic logic [3:0] burst_len(input logic [2:0] code);
    case (code)
      3'h0: burst_len = 4'h1;
      3'h1: burst_len = 4'h2;
      3'h2: burst_len = 4'h4;
      3'h3: burst_len = 4'h6;
      default: burst_len = 4'h8;
    endcase
  endfunction : burst_len

  //==========================================================
  // Bus slave
  drc_mem_ctrl_t mc;
  drc_timer_ctrl_t ts;
  logic [7:0] counter;
  logic [7:0] constant;
  logic dp_write;
  logic [3:0] dp_addr;
  logic clear_armed;
  logic [PRESC_W-1:0] presc;
  logic tick;
  logic match;
  logic pending;
  logic [3:0] burst_left;
  logic wr_mc;
  logic wr_ts;
  logic wr_cnt;
  logic wr_const;
  logic ap_take;
  logic [15:0] rd_word;

  assign ap_take = hsel && hready && htrans == HTRANS_NONSEQ;
  assign wr_mc = dp_write && dp_addr == OFS_MEMORY_CONTROL;
  assign wr_ts = dp_write && dp_addr == OFS_TIMER_CTRL;
  assign wr_cnt = dp_write && dp_addr == OFS_COUNTER;
  assign wr_const = dp_write && dp_addr == OFS_CONSTANT;

  // Read mux, reserved bits zero
  always_comb
  begin
    case (haddr[3:0])
      OFS_MEMORY_CONTROL: rd_word = {8'h00, mc.col_addr_width_sel[2], mc.memory_width_sel,
        mc.col_addr_width_sel[1:0], mc.refresh_enable_bit, mc.refresh_kind_sel, 2'h0};
      OFS_TIMER_CTRL: rd_word = {8'h00, ts};
      OFS_COUNTER: rd_word = {8'h00, counter};
      OFS_CONSTANT: rd_word = {8'h00, constant};
      default: rd_word = RESET_VALUE;
    endcase
  end

  // Address phase capture, read data prepared early
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write <= 1'b0;
      dp_addr <= OFS_MEMORY_CONTROL;
      hrdata <= RDATA_ZERO;
    end
    else
    begin
      dp_write <= ap_take && hwrite;
      dp_addr <= haddr[3:0];
      if (ap_take && !hwrite)
        hrdata <= {16'h0000, rd_word};
    end
  end

  // Zero-wait OKAY slave
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  //==========================================================
  // Memory control register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mc <= '0;
    else if (wr_mc)
    begin
      mc.col_addr_width_sel <= {hwdata[MC_COL_HI], hwdata[MC_COL_MID], hwdata[MC_COL_LO]};
      mc.memory_width_sel <= hwdata[MC_WIDTH];
      mc.refresh_enable_bit <= hwdata[MC_REFRESH_EN];
      mc.refresh_kind_sel <= hwdata[MC_REFRESH_KIND];
    end
  end

  // Geometry outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      geometry <= '0;
    else
    begin
      geometry.col_bits <= COL_BASE + {2'h0, mc.col_addr_width_sel[1:0]};
      geometry.bus_is_32 <= mc.memory_width_sel;
    end
  end

  //==========================================================
  // Timer control/status, flag set wins over clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ts <= '0;
    else
    begin
      if (wr_ts)
      begin
        ts.match_irq_enable <= hwdata[TS_MATCH_IRQ_EN];
        ts.timer_clock_div_sel <= hwdata[TS_DIV_LO +: 3];
        ts.refresh_burst_count <= hwdata[TS_BURST_LO +: 3];
      end
      if (match)
        ts.match_flag <= 1'b1;
      else if (wr_ts && clear_armed && !hwdata[TS_MATCH_FLAG])
        ts.match_flag <= 1'b0;
    end
  end

  // Read of a set flag arms the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      clear_armed <= 1'b0;
    else if (ap_take && !hwrite && haddr[3:0] == OFS_TIMER_CTRL && ts.match_flag)
      clear_armed <= 1'b1;
    else if (wr_ts || !ts.match_flag)
      clear_armed <= 1'b0;
  end

  // Interrupt follows flag and enable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      match_irq <= 1'b0;
    else
      match_irq <= ts.match_flag && ts.match_irq_enable;
  end

  //==========================================================
  // Prescaler
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      presc <= '0;
    else
      presc <= presc + 12'h001;
  end

  assign tick = ts.timer_clock_div_sel != 3'h0 &&
    (presc & div_mask(ts.timer_clock_div_sel)) == div_mask(ts.timer_clock_div_sel);
  assign match = tick && counter == constant;

  // Interval counter and constant
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      counter <= '0;
    else if (wr_cnt)
      counter <= hwdata[7:0];
    else if (match)
      counter <= '0;
    else if (tick)
      counter <= (counter == CNT_MAX) ? 8'h00 : counter + 8'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      constant <= '0;
    else if (wr_const)
      constant <= hwdata[7:0];
  end

  //==========================================================
  // Refresh request and burst issue
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pending <= 1'b0;
      burst_left <= '0;
      refresh_strobe <= 1'b0;
    end
    else
    begin
      refresh_strobe <= 1'b0;
      // Kind bit set stops normal refresh, so no strobe meets self-refresh entry
      if (!mc.refresh_enable_bit || mc.refresh_kind_sel || self_refresh)
      begin
        pending <= 1'b0;
        burst_left <= '0;
      end
      else if (match && !mc.refresh_kind_sel)
      begin
        pending <= 1'b1;
        burst_left <= burst_len(ts.refresh_burst_count);
      end
      else if (pending && !ext_access_busy)
      begin
        refresh_strobe <= 1'b1;
        burst_left <= burst_left - 4'h1;
        if (burst_left == 4'h1)
          pending <= 1'b0;
      end
    end
  end

  // Self-refresh entry waits for SDRAM access to end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      self_refresh <= 1'b0;
    else
      self_refresh <= mc.refresh_enable_bit && mc.refresh_kind_sel &&
        (self_refresh || !sdram_access_busy);
  end

  //==========================================================
  // Assertions
  property p_no_refresh_disabled;
    @(posedge hclk) disable iff (!hresetn)
    !mc.refresh_enable_bit |=> !refresh_strobe;
  endproperty
  a_no_refresh_disabled: assert property (p_no_refresh_disabled)
    else $error("refresh while disabled");

  property p_self_entry;
    @(posedge hclk) disable iff (!hresetn)
    mc.refresh_enable_bit && mc.refresh_kind_sel && !sdram_access_busy |=> self_refresh;
  endproperty
  a_self_entry: assert property (p_self_entry)
    else $error("self-refresh not entered");

  property p_wait_sdram;
    @(posedge hclk) disable iff (!hresetn)
    !self_refresh && sdram_access_busy |=> !self_refresh;
  endproperty
  a_wait_sdram: assert property (p_wait_sdram)
    else $error("self-refresh during SDRAM access");

  property p_hold_ext;
    @(posedge hclk) disable iff (!hresetn)
    ext_access_busy |=> !refresh_strobe;
  endproperty
  a_hold_ext: assert property (p_hold_ext)
    else $error("refresh during external access");

  property p_ignore_self;
    @(posedge hclk) disable iff (!hresetn)
    self_refresh |=> !refresh_strobe;
  endproperty
  a_ignore_self: assert property (p_ignore_self)
    else $error("refresh while in self-refresh");

  property p_flag_set;
    @(posedge hclk) disable iff (!hresetn)
    tick && counter == constant |=> ts.match_flag && (counter == 8'h00 || $past(wr_cnt));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("match did not set flag");

  property p_flag_clear;
    @(posedge hclk) disable iff (!hresetn)
    $fell(ts.match_flag) |-> $past(wr_ts) && $past(clear_armed);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag cleared without read");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    match_irq |-> $past(ts.match_flag) && $past(ts.match_irq_enable);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without enable");

  property p_frozen;
    @(posedge hclk) disable iff (!hresetn)
    ts.timer_clock_div_sel == 3'h0 && !wr_cnt |=> $stable(counter);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("counter moved while stopped");

  property p_burst_one;
    @(posedge hclk) disable iff (!hresetn)
    match && mc.refresh_enable_bit && !mc.refresh_kind_sel && !self_refresh
      && ts.refresh_burst_count == 3'h0 && !ext_access_busy
      ##1 !ext_access_busy && mc.refresh_enable_bit && !mc.refresh_kind_sel && !match
      |=> refresh_strobe ##1 !refresh_strobe;
  endproperty
  a_burst_one: assert property (p_burst_one)
    else $error("single refresh burst wrong");

  property p_upper_zero;
    @(posedge hclk) disable iff (!hresetn)
    hrdata[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper bits not zero");

  c_match: cover property (@(posedge hclk) disable iff (!hresetn) match);
  c_strobe: cover property (@(posedge hclk) disable iff (!hresetn) refresh_strobe ##1 refresh_strobe);
  c_self: cover property (@(posedge hclk) disable iff (!hresetn) $rose(self_refresh));
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $fell(match_irq));
endmodule : drc_refresh_ctrl

// [drc_pkg.sv]
//==========================================================
// Notes on behaviour
// - Column-address field codes 000 to 011 select 8 to 11 column bits.
// - Memory width bit sets DRAM data width: 0 is 16, 1 is 32 bits.
// - Refresh happens only while refresh enable is 1; reset value is 0.
// - With refresh enabled, writing refresh kind one enters self-refresh once no SDRAM access is in progress.
// - Normal refresh issues a refresh on every interval timer request.
// - A request arriving during an external access waits until it completes.
// - Self-refresh requested during an SDRAM access starts when that access ends.
// - Timer refresh requests are ignored while in self-refresh.
// - Upper eight bits of timer control/status read 0; software writes 0.
// - Match flag sets when interval counter equals interval constant.
// - Match flag clears only by writing 0 after reading it as 1.
// - Match interrupt raised only while match interrupt enable is 1.
// - Divider select 000 stops counting; others divide by 4 up to 4096.
// - Burst count field gives 1, 2, 4, 6 or 8 refreshes per request.
// - Counter clears on match and wraps to zero after 255.
// - Request held until served; an unserved one is dropped at next match.
// - Interrupt stays until flag cleared; clearing keeps pending refresh.
//==========================================================
package drc_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_MEMORY_CONTROL = 4'h0;
  localparam logic [3:0] OFS_TIMER_CTRL = 4'h4;
  localparam logic [3:0] OFS_COUNTER = 4'h8;
  localparam logic [3:0] OFS_CONSTANT = 4'hC;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  // Memory control bit positions
  localparam int MC_COL_HI = 7;
  localparam int MC_WIDTH = 6;
  localparam int MC_COL_MID = 5;
  localparam int MC_COL_LO = 4;
  localparam int MC_REFRESH_EN = 3;
  localparam int MC_REFRESH_KIND = 2;
  // Timer control/status bit positions
  localparam int TS_MATCH_FLAG = 7;
  localparam int TS_MATCH_IRQ_EN = 6;
  localparam int TS_DIV_LO = 3;
  localparam int TS_BURST_LO = 0;
  localparam int PRESC_W = 12;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [3:0] COL_BASE = 4'h8;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [2:0] col_addr_width_sel;
    logic memory_width_sel;
    logic refresh_enable_bit;
    logic refresh_kind_sel;
  } drc_mem_ctrl_t;

  typedef struct packed {
    logic match_flag;
    logic match_irq_enable;
    logic [2:0] timer_clock_div_sel;
    logic [2:0] refresh_burst_count;
  } drc_timer_ctrl_t;

  typedef struct packed {
    logic [3:0] col_bits;
    logic bus_is_32;
  } drc_geometry_t;
endpackage : drc_pkg

// [drc_dram_model.sv]
`timescale 1ns/1ps
module drc_dram_model
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Async reset, low
  input wire logic refresh_strobe, // Refresh pulse
  input wire logic self_refresh, // Self-refresh level
  input wire logic slow, // Stretch external accesses
  input wire logic hold_sdram, // Keep an SDRAM access open
  output logic ext_access_busy, // External access running
  output logic sdram_access_busy, // SDRAM access running
  output logic [15:0] refresh_count, // Refreshes seen
  output logic [7:0] bad_count // Refreshes at illegal moments
);
  logic [2:0] phase;
  logic busy_prev;

  //==========================================
  // Access traffic
  //==========================================
  // Five busy cycles of every eight when slow
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase <= 3'h0;
      ext_access_busy <= 1'b0;
      busy_prev <= 1'b0;
      sdram_access_busy <= 1'b0;
    end
    else
    begin
      phase <= phase + 3'h1;
      ext_access_busy <= slow && (phase < 3'h5);
      busy_prev <= ext_access_busy;
      sdram_access_busy <= hold_sdram;
    end
  end

  //==========================================
  // Refresh bookkeeping
  //==========================================
  // Strobes inside an external access or during self-refresh are faults
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      refresh_count <= 16'h0000;
      bad_count <= 8'h00;
    end
    else if (refresh_strobe)
    begin
      refresh_count <= refresh_count + 16'h0001;
      if (busy_prev || self_refresh)
        bad_count <= bad_count + 8'h01;
    end
  end
endmodule : drc_dram_model

// [drc_refresh_ctrl_bench.sv]
`timescale 1ns/1ps
module drc_refresh_ctrl_bench;
  import drc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic ext_busy, sdram_busy, strobe, self_ref, irq, slow, hold_sdram;
  logic [15:0] ref_cnt, n0;
  logic [7:0] bad_cnt, mc;
  logic [2:0] cs;
  logic wd;
  drc_geometry_t geometry;
  int failures, tests_run, n, w;

  //==========================================
  // Clock and instances
  //==========================================
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  assign hready = hreadyout;

  drc_refresh_ctrl i_drc_refresh_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext_access_busy(ext_busy), .sdram_access_busy(sdram_busy),
    .refresh_strobe(strobe), .self_refresh(self_ref), .match_irq(irq),
    .geometry(geometry));

  drc_dram_model i_drc_dram_model (.hclk(hclk), .hresetn(hresetn),
    .refresh_strobe(strobe), .self_refresh(self_ref), .slow(slow),
    .hold_sdram(hold_sdram), .ext_access_busy(ext_busy),
    .sdram_access_busy(sdram_busy), .refresh_count(ref_cnt), .bad_count(bad_cnt));

  //==========================================
  // Expectations
  //==========================================
  function automatic logic [4:0] geo_exp(input logic [7:0] m);
    return {4'h8 + {2'b00, m[5:4]}, m[6]};
  endfunction : geo_exp

  function automatic int ratio(input int c);
    return (c < 5) ? (4 ** c) : (1 << (c + 5));
  endfunction : ratio

  function automatic int burst_n(input int c);
    return (c == 0) ? 1 : ((c < 4) ? 2 * c : 8);
  endfunction : burst_n

  //==========================================
  // Bus and check tasks
  //==========================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  // One single AHB-Lite transfer, read data left in rd
  task automatic xfer(input logic wr_en, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr_en;
    htrans <= HTRANS_NONSEQ;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk

  // Let a few edges pass, then step clear of them
  task automatic tick(input int c);
    repeat (c) @(posedge hclk);
    #1;
  endtask : tick

  task automatic report_and_stop;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Watchdog against a hung handshake
  initial
  begin
    repeat (60000) @(posedge hclk);
    failures++;
    report_and_stop;
  end

  //==========================================
  // Main sequence
  //==========================================
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    htrans = 2'h0;
    hwdata = 32'h0000_0000;
    slow = 1'b0;
    hold_sdram = 1'b0;
    failures = 0;
    tests_run = 0;
    n = $urandom(50);
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, offset 0x10 aliasing offset 0 included
    for (int a = 0; a < 20; a += 4)
      rdchk(32'(a), 32'h0000_0000);
    check(hresp, 1'b0);
    // Column and width codes, corners then random
    for (int i = 0; i < 14; i++)
    begin
      cs = (i < 8) ? {1'b0, 2'(i)} : 3'($urandom);
      wd = (i < 8) ? i[2] : 1'($urandom);
      if (cs == 3'h6)
        cs = 3'h7;
      if (cs == 3'h1 || cs == 3'h2 || cs == 3'h5)
        wd = 1'b1;
      mc = {cs[2], wd, cs[1:0], 4'h0};
      wr(32'h0000_0000, 32'(mc));
      tick(2);
      check(geometry, geo_exp(mc));
      rdchk(32'h0000_0000, 32'(mc));
    end
    wr(32'h0000_0000, 32'h0000_0000);
    // Divider stopped freezes the counter
    wr(32'h0000_0008, 32'h0000_0005);
    tick(50);
    rdchk(32'h0000_0008, 32'h0000_0005);
    wr(32'h0000_000C, 32'h0000_00FF);
    for (int c = 1; c < 8; c++)
    begin
      w = ratio(c) * ((c < 5) ? 20 : 2);
      wr(32'h0000_0008, 32'h0000_0000);
      wr(32'h0000_0004, 32'(c << 3));
      repeat (w) @(posedge hclk);
      wr(32'h0000_0004, 32'h0000_0000);
      xfer(1'b0, 32'h0000_0008, 32'h0000_0000);
      n = w / ratio(c);
      check(int'(rd) >= n - 1 && int'(rd) <= n + 1, 1'b1);
    end
    // Match flag, interrupt and the read-then-write clear
    wr(32'h0000_000C, 32'h0000_0003);
    wr(32'h0000_0008, 32'h0000_0000);
    wr(32'h0000_0004, 32'h0000_0048);
    for (n = 0; n < 100 && irq !== 1'b1; n++)
      tick(1);
    check(irq, 1'b1);
    wr(32'h0000_0004, 32'h0000_0040);
    tick(2);
    check(irq, 1'b1);
    rdchk(32'h0000_0004, 32'h0000_00C0);
    wr(32'h0000_0004, 32'h0000_0040);
    tick(2);
    check(irq, 1'b0);
    rdchk(32'h0000_0004, 32'h0000_0040);
    wr(32'h0000_0004, 32'h0000_0008);
    tick(60);
    check(irq, 1'b0);
    rdchk(32'h0000_0004, 32'h0000_0088);
    wr(32'h0000_0004, 32'h0000_0000);
    check(ref_cnt, 16'h0000);
    // Burst counts, with external accesses in the way
    wr(32'h0000_000C, 32'h0000_0014);
    for (int c = 0; c < 5; c++)
    begin
      @(posedge hclk);
      slow <= (c == 4) | 1'($urandom);
      wr(32'h0000_0004, 32'h0000_0008 | 32'(c));
      n0 = ref_cnt;
      wr(32'h0000_0000, 32'h0000_0008);
      for (n = 0; n < 200 && ref_cnt == n0; n++)
        tick(1);
      tick(40);
      wr(32'h0000_0000, 32'h0000_0000);
      check(ref_cnt - n0, burst_n(c));
    end
    // Self-refresh held off by an open SDRAM access
    wr(32'h0000_0000, 32'h0000_0008);
    @(posedge hclk);
    hold_sdram <= 1'b1;
    wr(32'h0000_0000, 32'h0000_000C);
    tick(4);
    check(self_ref, 1'b0);
    @(posedge hclk);
    hold_sdram <= 1'b0;
    tick(3);
    check(self_ref, 1'b1);
    n0 = ref_cnt;
    tick(200);
    check(ref_cnt - n0, 16'h0000);
    wr(32'h0000_0000, 32'h0000_0008);
    tick(2);
    check(self_ref, 1'b0);
    wr(32'h0000_0000, 32'h0000_000C);
    tick(2);
    check(self_ref, 1'b1);
    wr(32'h0000_0000, 32'h0000_0000);
    check(bad_cnt, 8'h00);
    report_and_stop;
  end
endmodule : drc_refresh_ctrl_bench
